// ==== rtl/hub_descriptor_config_loader.sv ====
module hub_descriptor_config_loader #(
  parameter logic [15:0] DEF_VENDOR = 16'h0001, // arbitrary value
  parameter logic [15:0] DEF_PRODUCT = 16'h0002, // arbitrary value
  parameter logic [15:0] DEF_BCD = 16'h0100, // arbitrary value
  parameter int QTR_CYCLES = hub_cfg_pkg::QTR_CYC // mclk per quarter bit
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic portCountStrapHigh,
  input wire logic portCountStrapLow,
  input wire logic nonremovableStrapBit2,
  input wire logic nonremovableStrapBit1,
  input wire logic nonremovableStrapBit0,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  output logic portOneIndicatorOrSerialClockOut,
  output logic portOneIndicatorOrSerialClockOe,
  input wire logic suspendCmd,
  input wire logic [7:1] indicatorReq,
  output logic configDone,
  output logic imageValid,
  output logic [15:0] vendorId,
  output logic [15:0] productId,
  output logic [15:0] bcdDevice,
  output logic [7:0] nbrPorts,
  output logic [7:0] deviceRemovable,
  output logic [15:0] hubCharacteristics,
  output logic [9:0] hubContrCurrent,
  output logic [7:1] ledEnable,
  output logic [7:1] indicatorDrive,
  output logic lowPower
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  hub_cfg_pkg::load_state_t state_q;
  logic [4:0] strapMeta_q, strapSync_q, strapCap_q;
  logic sdaMeta_q, sdaSync_q;
  logic [1:0] waitCnt_q, phase_q, step_q;
  logic [7:0] qtrCnt_q, shift_q, xorAcc_q;
  logic [3:0] bitCnt_q;
  logic [4:0] byteIdx_q;
  logic ackBit_q, nack_q, valid_q, done_q;
  logic sclLow_q, sdaLow_q, sclLowD, sdaLowD;
  logic [7:0] image [0:hub_cfg_pkg::IMAGE_BYTES-1];
  logic [15:0] vid_q, pid_q, bcd_q, hubChar_q;
  logic [7:0] ports_q, remov_q, serLen_q;
  logic [9:0] cur_q;
  logic [7:1] led_q, drive_q;
  logic susp_q, ack_q;
  logic [31:0] dat_q, rdData;
  logic busy, tick, validNow, wbTake, reload;
  logic [7:0] strapRemov;
  logic [2:0] strapPorts;
  logic [7:0] imgXor;

  // all checks run on mclk and rest while reset is low
  default clocking chkClk @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // two flops on the strap pins and the serial data pin
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      strapMeta_q <= 5'h1f;
      strapSync_q <= 5'h1f;
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
    end else begin
      strapMeta_q <= {portCountStrapHigh, portCountStrapLow,
        nonremovableStrapBit2, nonremovableStrapBit1,
        nonremovableStrapBit0};
      strapSync_q <= strapMeta_q;
      sdaMeta_q <= serialDataIn;
      sdaSync_q <= sdaMeta_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      strapCap_q <= 5'h1f;
    end else if (state_q == hub_cfg_pkg::ST_STRAP && waitCnt_q == 2'h3) begin
      strapCap_q <= strapSync_q;
    end
  end

  // port pair decode, low tie counts as zero
  assign strapPorts = hub_cfg_pkg::MIN_PORTS +
    {1'b0, strapCap_q[3], strapCap_q[4]};

  always_comb begin
    case (~strapCap_q[2:0])
      3'h0: strapRemov = 8'h00;
      3'h1: strapRemov = 8'h04;
      3'h2: strapRemov = 8'h0c;
      3'h3: strapRemov = 8'h0e;
      3'h4: strapRemov = 8'h1e;
      3'h5: strapRemov = 8'h3e;
      3'h6: strapRemov = 8'h7e;
      default: strapRemov = 8'hfe;
    endcase
  end

  // ----------------------------------------
  // bit timing
  // ----------------------------------------
  assign busy = state_q == hub_cfg_pkg::ST_START ||
    state_q == hub_cfg_pkg::ST_TX || state_q == hub_cfg_pkg::ST_RX ||
    state_q == hub_cfg_pkg::ST_STOP;
  assign tick = qtrCnt_q == 8'(QTR_CYCLES - 1);

  // quarter-bit counter and phase
  always_ff @(posedge mclk) begin
    if (!reset_n || reload || !busy) begin
      qtrCnt_q <= 8'h00;
      phase_q <= 2'h0;
    end else if (tick) begin
      qtrCnt_q <= 8'h00;
      phase_q <= phase_q + 2'h1;
    end else begin
      qtrCnt_q <= qtrCnt_q + 8'h01;
    end
  end

  // line levels per state and phase
  always_comb begin
    sclLowD = 1'b0;
    sdaLowD = 1'b0;
    case (state_q)
      hub_cfg_pkg::ST_START: begin
        sclLowD = phase_q == 2'h0 || phase_q == 2'h3;
        sdaLowD = phase_q[1];
      end
      hub_cfg_pkg::ST_TX: begin
        sclLowD = phase_q == 2'h0 || phase_q == 2'h3;
        sdaLowD = bitCnt_q != 4'h8 && !shift_q[7];
      end
      hub_cfg_pkg::ST_RX: begin
        sclLowD = phase_q == 2'h0 || phase_q == 2'h3;
        sdaLowD = bitCnt_q == 4'h8 && byteIdx_q != 5'h1f;
      end
      hub_cfg_pkg::ST_STOP: begin
        sclLowD = phase_q == 2'h0;
        sdaLowD = !phase_q[1];
      end
      default: begin
        sclLowD = 1'b0;
        sdaLowD = 1'b0;
      end
    endcase
  end

  // open-drain drivers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sclLow_q <= 1'b0;
      sdaLow_q <= 1'b0;
    end else begin
      sclLow_q <= sclLowD;
      sdaLow_q <= sdaLowD;
    end
  end

  assign serialDataOut = 1'b0;
  assign serialDataOe = sdaLow_q;
  assign portOneIndicatorOrSerialClockOut = 1'b0;
  assign portOneIndicatorOrSerialClockOe = sclLow_q;

  // ----------------------------------------
  // load sequencer
  // ----------------------------------------
  // sequential read of the whole image
  always_ff @(posedge mclk) begin
    if (!reset_n || reload) begin
      state_q <= hub_cfg_pkg::ST_STRAP;
      waitCnt_q <= 2'h0;
      step_q <= 2'h0;
      bitCnt_q <= 4'h0;
      byteIdx_q <= 5'h00;
      shift_q <= 8'h00;
      xorAcc_q <= 8'h00;
      ackBit_q <= 1'b1;
      nack_q <= 1'b0;
      valid_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      case (state_q)
        hub_cfg_pkg::ST_STRAP: begin
          waitCnt_q <= waitCnt_q + 2'h1;
          if (waitCnt_q == 2'h3) begin
            state_q <= hub_cfg_pkg::ST_START;
          end
        end
        hub_cfg_pkg::ST_START: begin
          if (tick && phase_q == 2'h3) begin
            state_q <= hub_cfg_pkg::ST_TX;
            bitCnt_q <= 4'h0;
            shift_q <= step_q == 2'h2 ? hub_cfg_pkg::EEPROM_RD
                                      : hub_cfg_pkg::EEPROM_WR;
          end
        end
        hub_cfg_pkg::ST_TX: begin
          if (tick && phase_q == 2'h2) begin
            ackBit_q <= sdaSync_q;
          end
          if (tick && phase_q == 2'h3) begin
            if (bitCnt_q != 4'h8) begin
              bitCnt_q <= bitCnt_q + 4'h1;
              shift_q <= {shift_q[6:0], 1'b0};
            end else if (ackBit_q) begin
              nack_q <= 1'b1;
              state_q <= hub_cfg_pkg::ST_STOP;
            end else begin
              bitCnt_q <= 4'h0;
              step_q <= step_q + 2'h1;
              case (step_q)
                2'h0: shift_q <= hub_cfg_pkg::EEPROM_START;
                2'h1: state_q <= hub_cfg_pkg::ST_START;
                default: state_q <= hub_cfg_pkg::ST_RX;
              endcase
            end
          end
        end
        hub_cfg_pkg::ST_RX: begin
          if (tick && phase_q == 2'h2 && bitCnt_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sdaSync_q};
          end
          if (tick && phase_q == 2'h3) begin
            if (bitCnt_q != 4'h8) begin
              bitCnt_q <= bitCnt_q + 4'h1;
            end else begin
              bitCnt_q <= 4'h0;
              byteIdx_q <= byteIdx_q + 5'h01;
              if (byteIdx_q != hub_cfg_pkg::ADDR_SUM) begin
                xorAcc_q <= xorAcc_q ^ shift_q;
              end else begin
                state_q <= hub_cfg_pkg::ST_STOP;
              end
            end
          end
        end
        hub_cfg_pkg::ST_STOP: begin
          if (tick && phase_q == 2'h3) begin
            state_q <= hub_cfg_pkg::ST_EVAL;
          end
        end
        hub_cfg_pkg::ST_EVAL: begin
          valid_q <= validNow;
          done_q <= 1'b1;
          state_q <= hub_cfg_pkg::ST_DONE;
        end
        hub_cfg_pkg::ST_DONE: begin
          done_q <= 1'b1;
        end
        default: begin
          state_q <= hub_cfg_pkg::ST_STRAP;
        end
      endcase
    end
  end

  // image store, one byte per ack slot
  always_ff @(posedge mclk) begin
    if (state_q == hub_cfg_pkg::ST_RX && tick && phase_q == 2'h3 &&
        bitCnt_q == 4'h8) begin
      image[byteIdx_q] <= shift_q;
    end
  end

  // check bytes and checksum gate the image
  assign validNow = !nack_q && image[0] == hub_cfg_pkg::CHECK0_VAL &&
    image[1] == hub_cfg_pkg::CHECK1_VAL &&
    xorAcc_q == image[hub_cfg_pkg::ADDR_SUM];

  // independent xor of the stored bytes, for the checks
  always_comb begin
    imgXor = 8'h00;
    for (int i = 0; i < hub_cfg_pkg::IMAGE_BYTES - 1; i++) begin
      imgXor = imgXor ^ image[i];
    end
  end

  // ----------------------------------------
  // descriptor values
  // ----------------------------------------
  // defaults, with port count and removable map from straps, unless image passed every check
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      vid_q <= DEF_VENDOR;
      pid_q <= DEF_PRODUCT;
      bcd_q <= DEF_BCD;
      ports_q <= 8'h07;
      remov_q <= 8'h00;
      serLen_q <= 8'h00;
      hubChar_q <= 16'h0000;
      cur_q <= hub_cfg_pkg::CUR_LOW_MA;
    end else if (state_q == hub_cfg_pkg::ST_EVAL) begin
      if (validNow) begin
        vid_q <= {image[hub_cfg_pkg::ADDR_VID_LO + 5'h01],
                  image[hub_cfg_pkg::ADDR_VID_LO]};
        pid_q <= {image[hub_cfg_pkg::ADDR_PID_LO + 5'h01],
                  image[hub_cfg_pkg::ADDR_PID_LO]};
        bcd_q <= {image[hub_cfg_pkg::ADDR_REL_LO + 5'h01],
                  image[hub_cfg_pkg::ADDR_REL_LO]};
        ports_q <= image[hub_cfg_pkg::ADDR_PORTS];
        remov_q <= image[hub_cfg_pkg::ADDR_REMOV] & 8'hfe;
        serLen_q <= image[hub_cfg_pkg::ADDR_SERLEN];
        hubChar_q <= 16'h0000;
        hubChar_q[hub_cfg_pkg::HUBCHAR_IND_BIT] <=
          image[hub_cfg_pkg::ADDR_ATTR][hub_cfg_pkg::ATTR_IND_BIT];
        hubChar_q[hub_cfg_pkg::HUBCHAR_COMP_BIT] <=
          image[hub_cfg_pkg::ADDR_ATTR][hub_cfg_pkg::ATTR_COMP_BIT];
        cur_q <= image[hub_cfg_pkg::ADDR_ATTR][hub_cfg_pkg::ATTR_CUR_BIT]
          ? hub_cfg_pkg::CUR_HIGH_MA : hub_cfg_pkg::CUR_LOW_MA;
      end else begin
        vid_q <= DEF_VENDOR;
        pid_q <= DEF_PRODUCT;
        bcd_q <= DEF_BCD;
        ports_q <= {5'h00, strapPorts};
        remov_q <= strapRemov;
        serLen_q <= 8'h00;
        hubChar_q <= 16'h0000;
        cur_q <= hub_cfg_pkg::CUR_LOW_MA;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n || reload) begin
      led_q <= 7'h00;
    end else if (state_q == hub_cfg_pkg::ST_DONE) begin
      for (int n = 1; n <= 7; n++) begin
        led_q[n] <= 8'(n) <= ports_q && !(remov_q[n] && !valid_q);
      end
    end
  end

  // indicator requests act only when supported
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      drive_q <= 7'h00;
      susp_q <= 1'b0;
    end else begin
      drive_q <= hubChar_q[hub_cfg_pkg::HUBCHAR_IND_BIT] && !susp_q
        ? indicatorReq & led_q : 7'h00;
      susp_q <= suspendCmd;
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  assign wbTake = wb_cyc_i && wb_stb_i && !ack_q;
  assign reload = wbTake && wb_we_i && wb_sel_i[0] &&
    wb_adr_i == hub_cfg_pkg::REG_CTRL &&
    wb_dat_i[hub_cfg_pkg::CTRL_RELOAD_BIT];

  // read mux, serial chars past the length read zero
  always_comb begin
    rdData = 32'h0000_0000;
    case (wb_adr_i)
      hub_cfg_pkg::REG_CTRL: begin
        rdData[hub_cfg_pkg::CTRL_DONE_BIT] = done_q;
        rdData[hub_cfg_pkg::CTRL_VALID_BIT] = valid_q;
        rdData[hub_cfg_pkg::CTRL_NACK_BIT] = nack_q;
        rdData[hub_cfg_pkg::CTRL_SUSP_BIT] = susp_q;
      end
      hub_cfg_pkg::REG_IDS: rdData = {pid_q, vid_q};
      hub_cfg_pkg::REG_REL: rdData = {remov_q, ports_q, bcd_q};
      hub_cfg_pkg::REG_HUB: begin
        rdData = {1'b0, hub_cfg_pkg::NUM_CONFIGS, 2'h0, cur_q, hubChar_q};
        rdData[hub_cfg_pkg::HUB_SELF_BIT] = 1'b1;
      end
      hub_cfg_pkg::REG_SERLEN: rdData = {24'h000000, serLen_q};
      default: begin
        // serial text, four chars a word
        if (wb_adr_i[7:4] == hub_cfg_pkg::REG_SERIAL[7:4] && valid_q) begin
          for (int j = 0; j < 4; j++) begin
            if (8'({wb_adr_i[3:2], 2'(j)}) < serLen_q) begin
              rdData[8*j +: 8] = image[hub_cfg_pkg::ADDR_SERIAL +
                5'({wb_adr_i[3:2], 2'(j)})];
            end
          end
        end
      end
    endcase
  end

  // registered one-cycle ack
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wbTake;
      if (wbTake) begin
        dat_q <= rdData;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign configDone = done_q;
  assign imageValid = valid_q;
  assign vendorId = vid_q;
  assign productId = pid_q;
  assign bcdDevice = bcd_q;
  assign nbrPorts = ports_q;
  assign deviceRemovable = remov_q;
  assign hubCharacteristics = hubChar_q;
  assign hubContrCurrent = cur_q;
  assign ledEnable = led_q;
  assign indicatorDrive = drive_q;
  assign lowPower = susp_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_check_bytes: assert property (
    valid_q |-> image[0] == 8'h40 && image[1] == 8'h1a)
    else $error("valid image without check bytes");
  chk_xor_sum: assert property (
    valid_q |-> imgXor == image[hub_cfg_pkg::ADDR_SUM])
    else $error("checksum accepted wrongly");
  chk_vendor_id: assert property (
    $rose(valid_q) |-> vid_q == {image[3], image[2]} &&
    pid_q == {image[5], image[4]})
    else $error("ids not taken from image");
  chk_default_ids: assert property (
    $rose(done_q) && !valid_q |-> vid_q == DEF_VENDOR &&
    ports_q == {5'h00, strapPorts} && serLen_q == 8'h00)
    else $error("defaults not used");
  chk_port_override: assert property (
    $rose(valid_q) |-> ports_q == image[26])
    else $error("port count not from image");
  chk_strap_ports: assert property (
    done_q && !valid_q |-> ports_q >= 8'h04 && ports_q <= 8'h07)
    else $error("strap port count out of range");
  chk_current_sel: assert property (
    $rose(valid_q) |-> cur_q == (image[30][2] ? 10'h1f4 : 10'h0c8))
    else $error("controller current wrong");
  chk_led_unused: assert property (
    done_q && ports_q == 8'h04 |=> led_q[7:5] == 3'h0)
    else $error("indicator on for unusable port");
  chk_suspend: assert property (
    suspendCmd [*2] |-> susp_q)
    else $error("suspend not entered");
  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule : hub_descriptor_config_loader

// ==== pkg/hub_cfg_pkg.sv ====
// Operation
// - sample straps on every reset, then apply
// - image valid only if bytes 0x40, 0x1a
// - byte 0x1f checks bytes 0x00..0x1e
// - bad image: use defaults and straps
// - vendor id from bytes 0x02, 0x03
// - product id from bytes 0x04, 0x05
// - release bcd from bytes 0x06, 0x07
// - serial text in 0x08..0x17, max 16
// - serial length from 0x18 limits reported chars
// - port count from 0x1a overrides straps
// - removable map from 0x1c overrides straps
// - attribute bit0 sets indicator support bit7
// - attribute bit1 sets compound bit2
// - attribute bit2 picks 200 or 500 mA
// - straps cut ports from seven to four
// - port strap pair decodes four to seven
// - unusable ports get indicators disabled
// - one configuration, always self powered
// - suspend when the host commands it
// - three straps mark non-removable port runs
// - eeprom sits on shared data, clock pins
package hub_cfg_pkg;
  // ----------------------------------------
  // eeprom image layout
  // ----------------------------------------
  localparam int IMAGE_BYTES = 32;
  localparam logic [4:0] ADDR_VID_LO = 5'h02;
  localparam logic [4:0] ADDR_PID_LO = 5'h04;
  localparam logic [4:0] ADDR_REL_LO = 5'h06;
  localparam logic [4:0] ADDR_SERIAL = 5'h08;
  localparam logic [4:0] ADDR_SERLEN = 5'h18;
  localparam logic [4:0] ADDR_PORTS = 5'h1a;
  localparam logic [4:0] ADDR_REMOV = 5'h1c;
  localparam logic [4:0] ADDR_ATTR = 5'h1e;
  localparam logic [4:0] ADDR_SUM = 5'h1f;
  localparam logic [7:0] CHECK0_VAL = 8'h40;
  localparam logic [7:0] CHECK1_VAL = 8'h1a;
  localparam int SERIAL_MAX = 16;
  localparam int ATTR_IND_BIT = 0;
  localparam int ATTR_COMP_BIT = 1;
  localparam int ATTR_CUR_BIT = 2;
  localparam int HUBCHAR_IND_BIT = 7;
  localparam int HUBCHAR_COMP_BIT = 2;
  localparam logic [9:0] CUR_LOW_MA = 10'h0c8;
  localparam logic [9:0] CUR_HIGH_MA = 10'h1f4;
  localparam logic [2:0] MIN_PORTS = 3'h4;
  localparam logic [7:0] EEPROM_WR = 8'ha0;
  localparam logic [7:0] EEPROM_RD = 8'ha1;
  localparam logic [7:0] EEPROM_START = 8'h00;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 20;
  localparam int I2C_BIT_NS = 10000;
  localparam int QTR_CYC = (I2C_BIT_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
  // ----------------------------------------
  // wishbone register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_IDS = 8'h04;
  localparam logic [7:0] REG_REL = 8'h08;
  localparam logic [7:0] REG_HUB = 8'h0c;
  localparam logic [7:0] REG_SERLEN = 8'h10;
  localparam logic [7:0] REG_SERIAL = 8'h20;
  localparam int CTRL_DONE_BIT = 0;
  localparam int CTRL_VALID_BIT = 1;
  localparam int CTRL_NACK_BIT = 2;
  localparam int CTRL_SUSP_BIT = 3;
  localparam int CTRL_RELOAD_BIT = 0;
  localparam int HUB_SELF_BIT = 26;
  localparam logic [2:0] NUM_CONFIGS = 3'h1;

  typedef enum logic [2:0] {
    ST_STRAP, ST_START, ST_TX, ST_RX, ST_STOP, ST_EVAL, ST_DONE
  } load_state_t;
endpackage : hub_cfg_pkg

// ==== sim/eeprom_model.sv ====
module eeprom_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic nackMode,
  input wire logic [255:0] image,
  output logic sdaOe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] b;
  logic [4:0] idx;
  logic m;
  // ----------------------------------------
  // bus helpers
  // ----------------------------------------
  // start is data falling while clock high
  task automatic waitStart();
    do @(negedge sda); while (scl !== 1'b1);
  endtask : waitStart
  // byte in, msb first, taken on clock rise
  task automatic rxByte(output logic [7:0] v);
    repeat (8) begin
      @(posedge scl);
      v = {v[6:0], sda};
    end
  endtask : rxByte
  // pull data low for the acknowledge bit only
  task automatic ackBit();
    @(negedge scl);
    sdaOe = 1'b1;
    @(negedge scl);
    sdaOe = 1'b0;
  endtask : ackBit
  // ----------------------------------------
  // sequential read responder
  // ----------------------------------------
  // open drain, released line floats high
  initial begin
    sdaOe = 1'b0;
    forever begin
      waitStart();
      rxByte(b);
      if (nackMode === 1'b1) continue; // absent memory stays silent
      ackBit();
      rxByte(b);
      idx = b[4:0];
      ackBit();
      waitStart();
      rxByte(b);
      ackBit();
      m = 1'b0;
      while (m == 1'b0) begin
        b = image[idx*8 +: 8];
        for (int i = 7; i >= 0; i--) begin
          sdaOe = ~b[i]; // data changes only while clock low
          @(negedge scl);
        end
        sdaOe = 1'b0;
        @(posedge scl);
        m = sda;
        @(negedge scl);
        idx = idx + 5'h01;
      end
    end
  end
endmodule : eeprom_model

// ==== sim/hub_descriptor_config_loader_test.sv ====
module hub_descriptor_config_loader_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] VID0 = 16'h0a0b; // arbitrary value
  localparam logic [15:0] PID0 = 16'h0c0d; // arbitrary value
  localparam logic [15:0] BCD0 = 16'h0311; // arbitrary value
  logic mclk, reset_n, wbCyc, wbStb, wbWe, wbAck, pcHigh, pcLow;
  logic [7:0] wbAdr, nbrPorts, devRem, rem, img [32];
  logic [31:0] wbDatW, wbDatR, rd;
  logic [3:0] wbSel;
  logic [2:0] nrStrap;
  logic dutOe, sclOe, memOe, sda, scl, nackMode, suspendCmd;
  logic lowPower, configDone, imageValid;
  logic [7:1] indReq, ledEnable, indDrive;
  logic [15:0] vendorId, productId, bcdDevice, hubChar;
  logic [9:0] curMa;
  logic [255:0] image;
  int error_cnt, total_checks, v, p;
  assign sda = ~(dutOe | memOe);
  assign scl = ~sclOe;
  hub_descriptor_config_loader #(.DEF_VENDOR(VID0), .DEF_PRODUCT(PID0),
    .DEF_BCD(BCD0), .QTR_CYCLES(8)) dut_u (.mclk(mclk),
    .reset_n(reset_n),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_dat_i(wbDatW), .wb_sel_i(wbSel), .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck), .portCountStrapHigh(pcHigh),
    .portCountStrapLow(pcLow), .nonremovableStrapBit2(nrStrap[2]),
    .nonremovableStrapBit1(nrStrap[1]), .nonremovableStrapBit0(nrStrap[0]),
    .serialDataIn(sda), .serialDataOut(), .serialDataOe(dutOe),
    .portOneIndicatorOrSerialClockOut(),
    .portOneIndicatorOrSerialClockOe(sclOe), .suspendCmd(suspendCmd),
    .indicatorReq(indReq), .configDone(configDone),
    .imageValid(imageValid), .vendorId(vendorId), .productId(productId),
    .bcdDevice(bcdDevice), .nbrPorts(nbrPorts), .deviceRemovable(devRem),
    .hubCharacteristics(hubChar), .hubContrCurrent(curMa),
    .ledEnable(ledEnable), .indicatorDrive(indDrive), .lowPower(lowPower));
  eeprom_model mem_u (.scl(scl), .sda(sda), .nackMode(nackMode),
    .image(image), .sdaOe(memOe));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // verdict and end of run
  task automatic end_sim();
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // one comparison
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // classic wishbone cycle, held until ack
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatW <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask : xfer
  // bounded wait for the load to finish
  task automatic waitDone();
    int n;
    n = 0;
    while (configDone !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    check("configDone", 32'h1, 32'(configDone));
  endtask : waitDone
  // restart load, straps captured again
  task automatic reload();
    xfer(1'b1, hub_cfg_pkg::REG_CTRL, 32'h1, rd);
    repeat (4) @(posedge mclk);
    waitDone();
  endtask : reload
  // ----------------------------------------
  // clock, watchdog
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    end_sim();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    error_cnt = 0;
    total_checks = 0;
    reset_n = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbDatW = 32'h0;
    wbSel = 4'hf;
    pcHigh = 1'b1;
    pcLow = 1'b1;
    nrStrap = 3'h7;
    nackMode = 1'b1;
    suspendCmd = 1'b0;
    indReq = 7'h00;
    image = 256'h0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    waitDone();
    check("nbrPorts", 32'h7, 32'(nbrPorts));
    xfer(1'b0, hub_cfg_pkg::REG_CTRL, 32'h0, rd);
    check("ctrl", 32'h5, rd);
    // absent memory: all eight removable strap patterns, each port pair twice
    for (int k = 0; k < 8; k++) begin
      pcHigh <= k[0];
      pcLow <= k[1];
      nrStrap <= k[2:0];
      reload();
      p = 4 + 2 * k[1] + k[0];
      v = 7 - k;
      rem = (v == 0) ? 8'h00 : (v == 1) ? 8'h04 : (v == 2) ? 8'h0c :
            8'((1 << (v + 1)) - 2);
      check("nbrPorts", 32'(p), 32'(nbrPorts));
      check("removable", 32'(rem), 32'(devRem));
      check("ledEnable", 32'(8'((1 << (p + 1)) - 2) & ~rem) >> 1,
            32'(ledEnable));
      check("valid", 32'h0, 32'(imageValid));
      check("vendor", 32'(VID0), 32'(vendorId));
    end
    // good image, straps say four ports
    img[0] = 8'h40;
    img[1] = 8'h1a;
    img[2] = 8'h67;
    img[3] = 8'h45;
    img[4] = 8'h89;
    img[5] = 8'h12;
    img[6] = 8'h25;
    img[7] = 8'h01;
    for (int i = 0; i < 16; i++) img[8 + i] = 8'h41 + 8'(i);
    img[24] = 8'h05;
    img[25] = 8'h00;
    img[26] = 8'h05;
    img[27] = 8'h00;
    img[28] = 8'h06;
    img[29] = 8'h00;
    img[30] = 8'h07;
    img[31] = 8'h00;
    for (int i = 0; i < 31; i++) img[31] = img[31] ^ img[i];
    for (int i = 0; i < 32; i++) image[8 * i +: 8] <= img[i];
    pcHigh <= 1'b0;
    pcLow <= 1'b0;
    nackMode <= 1'b0;
    reload();
    check("valid", 32'h1, 32'(imageValid));
    xfer(1'b0, hub_cfg_pkg::REG_IDS, 32'h0, rd);
    check("ids", 32'h12894567, rd);
    xfer(1'b0, hub_cfg_pkg::REG_REL, 32'h0, rd);
    check("release", 32'h06050125, rd);
    check("bcd", 32'h0125, 32'(bcdDevice));
    xfer(1'b0, hub_cfg_pkg::REG_HUB, 32'h0, rd);
    check("hubword", 32'h15f4, 32'(rd[31:16]));
    check("hubchar", 32'h3, 32'({hubChar[7], hubChar[2]}));
    check("current", 32'h1f4, 32'(curMa));
    check("ledEnable", 32'h1f, 32'(ledEnable));
    xfer(1'b0, hub_cfg_pkg::REG_SERLEN, 32'h0, rd);
    check("serlen", 32'h5, rd);
    xfer(1'b0, hub_cfg_pkg::REG_SERIAL, 32'h0, rd);
    check("serial0", 32'h44434241, rd);
    xfer(1'b0, 8'h24, 32'h0, rd);
    check("serial1", 32'h45, rd);
    indReq <= 7'h7f;
    repeat (3) @(posedge mclk);
    check("indicator", 32'h1f, 32'(indDrive));
    suspendCmd <= 1'b1;
    repeat (3) @(posedge mclk);
    check("lowPower", 32'h1, 32'(lowPower));
    check("indicator", 32'h0, 32'(indDrive));
    xfer(1'b0, hub_cfg_pkg::REG_CTRL, 32'h0, rd);
    check("ctrl", 32'hb, rd);
    suspendCmd <= 1'b0;
    xfer(1'b1, 8'h40, 32'hffffffff, rd);
    xfer(1'b0, 8'h40, 32'h0, rd);
    check("unmapped", 32'h0, rd);
    // one checksum bit wrong
    image[255:248] <= image[255:248] ^ 8'h01;
    reload();
    check("valid", 32'h0, 32'(imageValid));
    check("vendor", 32'(VID0), 32'(vendorId));
    check("product", 32'(PID0), 32'(productId));
    check("nbrPorts", 32'h4, 32'(nbrPorts));
    check("removable", 32'h00, 32'(devRem));
    check("bcd", 32'(BCD0), 32'(bcdDevice));
    check("ledEnable", 32'h0f, 32'(ledEnable));
    check("indicator", 32'h0, 32'(indDrive));
    end_sim();
  end
endmodule : hub_descriptor_config_loader_test
